// ---- verif/pcsr_smi_ctrl.sv ----
// Management bus controller model for the register pair
`timescale 1ns/1ps
`default_nettype none
module pcsr_smi_ctrl (
  input wire logic mclk_in,    // core clock
  input wire logic dev_out_in, // device drive value
  input wire logic dev_oe_in,  // device drive enable
  output logic mdc_out,        // management clock
  output logic pin_out         // resolved data line
);
  import pcsr_pkg::*;
  logic drv_r = 1'b1;
  logic oe_r = 1'b0;
  // Pull-up wins when nobody drives the line
  assign pin_out = dev_oe_in ? dev_out_in : (oe_r ? drv_r : 1'b1);
  initial mdc_out = 1'b0;
  task automatic half(input int n);
    repeat (n) @(negedge mclk_in);
  endtask
  // Data changes in the low phase, device samples on the rise
  task automatic frame(input logic [1:0] op, input logic [4:0] phy,
      input logic [4:0] rg, input logic [15:0] wd, output logic [15:0] rd);
    logic [31:0] v;
    v = {2'b01, op, phy, rg, 2'b10, wd};
    rd = 16'h0000;
    for (int i = 0; i < 64; i++) begin
      half(1);
      mdc_out = 1'b0;
      oe_r = !(op == OP_RD && i >= 46);
      drv_r = (i < 32) ? 1'b1 : v[63 - i];
      half(3);
      if (i >= 48) begin
        rd = {rd[14:0], pin_out};
      end
      mdc_out = 1'b1;
      half(3);
    end
    half(1);
    mdc_out = 1'b0;
    oe_r = 1'b0;
  endtask
endmodule
`default_nettype wire

// ---- verif/test_phy_control_status_regs.sv ----
// Self-checking bench for the control and status register pair
`timescale 1ns/1ps
`default_nettype none
module test_phy_control_status_regs;
  import pcsr_pkg::*;
  localparam int PC = 20;
  logic mclk_in = 1'b0;
  logic rst_in = 1'b1;
  logic mdc, pin, mo, moe, strap = 1'b1;
  logic [1:0] speed = 2'h0;
  logic dup = 1'b0, page = 1'b0, an_en = 1'b0, an_done = 1'b0;
  logic an_busy = 1'b0, lq = 1'b0, cd = 1'b0, ab = 1'b0, dsh = 1'b0;
  logic pdet = 1'b0, pdpin = 1'b0, bcpd = 1'b0;
  logic [3:0] pol = 4'h0;
  logic [3:0] txd, rxd;
  logic txe, rxe, sge, lnk, slp, bpd, pll, lpl, pdo, dpd, xa, xs, ck, inv, jab;
  logic [15:0] rv;
  logic [15:0] dep [4] = '{16'h3, 16'h4, 16'h6, 16'h8};
  int errors = 0;
  int check_count = 0;
  int n;
  always #4 mclk_in = ~mclk_in;
  pcsr_regs #(.PULSE_CYC(PC)) pcsr_regs_i (.mclk_in(mclk_in),
    .rst_in(rst_in), .mdc_in(mdc), .mdio_in(pin), .mdio_out(mo),
    .mdio_oe_out(moe), .phy_addr_in(5'h01), .sgmii_strap_in(strap),
    .speed_in(speed), .full_duplex_in(dup), .page_rx_in(page),
    .an_enabled_in(an_en), .an_done_in(an_done), .an_busy_in(an_busy),
    .link_qual_in(lq), .pair_cd_swapped_in(cd), .pair_ab_swapped_in(ab),
    .downshift_active_in(dsh), .channel_polarity_flip_in(pol),
    .partner_detect_in(pdet), .pd_pin_in(pdpin),
    .basic_control_pd_in(bcpd), .tx_fifo_depth_out(txd),
    .tx_fifo_en_out(txe), .rx_fifo_depth_out(rxd), .rx_fifo_en_out(rxe),
    .sgmii_en_out(sge), .link_up_out(lnk), .sleep_out(slp),
    .block_pd_out(bpd), .pll_pd_out(pll), .link_pulse_out(lpl),
    .pd_out(pdo), .deep_pd_out(dpd), .pair_swap_auto_out(xa),
    .pair_swap_select_out(xs), .fast_clock_out_en_out(ck),
    .tx_invert_on_out(inv), .jabber_en_out(jab));
  pcsr_smi_ctrl pcsr_smi_ctrl_i (.mclk_in(mclk_in), .dev_out_in(mo),
    .dev_oe_in(moe), .mdc_out(mdc), .pin_out(pin));
  task automatic check(input string what, input logic [15:0] seen,
      input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      errors++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic bit1(input string what, input logic seen, input logic exp);
    check(what, {15'h0000, seen}, {15'h0000, exp});
  endtask
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    pcsr_smi_ctrl_i.frame(OP_WR, 5'h01, a, d, rv);
    repeat (2) @(negedge mclk_in);
  endtask
  task automatic rd(input logic [4:0] a, input logic [15:0] m,
      input logic [15:0] exp, input string what);
    pcsr_smi_ctrl_i.frame(OP_RD, 5'h01, a, 16'h0000, rv);
    check(what, rv & m, exp);
  endtask
  task automatic report_and_stop;
    $display("Checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (100000) @(posedge mclk_in);
    errors++;
    report_and_stop();
  end
  initial begin
    repeat (5) @(negedge mclk_in);
    rst_in = 1'b0;
    repeat (4) @(negedge mclk_in);
    rd(REG_CTL, 16'hFFFF, 16'h5848, "ctl reset");
    bit1("sgmii", sge, 1'b1);
    bit1("auto x", xa, 1'b1);
    for (int c = 0; c < 4; c++) begin
      wr(REG_CTL, {c[1:0], c[1:0], 12'h800});
      check("tx depth", {12'h000, txd}, dep[c]);
      check("rx depth", {12'h000, rxd}, dep[c]);
      bit1("rx en", rxe, 1'b1);
    end
    wr(REG_CTL, 16'h0000);
    rd(REG_CTL, 16'hFFFF, 16'h0008, "ctl zero");
    bit1("rx en", rxe, 1'b0);
    bit1("tx en", txe, 1'b0);
    bit1("jabber", jab, 1'b1);
    bit1("clk out", ck, 1'b1);
    speed = 2'h2;
    @(negedge mclk_in);
    bit1("tx en", txe, 1'b1);
    wr(REG_CTL, 16'hFFFF);
    rd(REG_CTL, 16'hFFFF, 16'hFFFF, "ctl ones");
    bit1("inv", inv, 1'b1);
    bit1("jabber", jab, 1'b0);
    bit1("clk out", ck, 1'b0);
    bit1("sleep", slp, 1'b1);
    bit1("link", lnk, 1'b0);
    wr(REG_CTL, 16'h0100);
    bit1("pd", bpd, 1'b1);
    bit1("pll", pll, 1'b1);
    wr(REG_CTL, 16'h0110);
    bit1("pll", pll, 1'b0);
    wr(REG_CTL, 16'h0300);
    pdet = 1'b1;
    repeat (4) @(negedge mclk_in);
    bit1("no wake", slp, 1'b1);
    pdet = 1'b0;
    wr(REG_CTL, 16'h0200);
    rd(REG_STS, 16'h0040, 16'h0040, "sleep st");
    n = 0;
    repeat (5 * PC) begin
      @(negedge mclk_in);
      n += (lpl === 1'b1);
    end
    check("pulses", 16'(n), 16'h0005);
    pdet = 1'b1;
    repeat (4) @(negedge mclk_in);
    bit1("wake", slp, 1'b0);
    pdet = 1'b0;
    pdpin = 1'b1;
    wr(REG_CTL, 16'h0000);
    check("pd", {14'h0000, pdo, dpd}, 16'h0002);
    wr(REG_CTL, 16'h0080);
    check("deep pd", {14'h0000, pdo, dpd}, 16'h0001);
    pdpin = 1'b0;
    bcpd = 1'b1;
    @(negedge mclk_in);
    check("deep pd", {14'h0000, pdo, dpd}, 16'h0001);
    bcpd = 1'b0;
    wr(REG_CTL, 16'h0400);
    bit1("forced", lnk, 1'b1);
    rd(REG_STS, 16'h0400, 16'h0400, "link st");
    wr(REG_CTL, 16'h0404);
    bit1("standby", lnk, 1'b0);
    wr(REG_CTL, 16'h0020);
    check("mdix", {14'h0000, xa, xs}, 16'h0001);
    wr(REG_CTL, 16'h0000);
    check("mdi", {14'h0000, xa, xs}, 16'h0000);
    {dup, an_en, an_done, lq, cd, dsh, an_busy} = 7'h7F;
    pol = 4'hA;
    rd(REG_STS, 16'hFFFF, 16'hAEA8, "status");
    wr(REG_STS, 16'h0000);
    rd(REG_STS, 16'hFFFF, 16'hAEA8, "status");
    // Swap the crossed pair group so both pair bits get exercised
    {speed, dup, an_done, lq, cd, ab, an_busy} = 8'h42;
    rd(REG_STS, 16'hFFFF, 16'h4100, "status");
    an_en = 1'b0;
    page = 1'b1;
    @(negedge mclk_in);
    page = 1'b0;
    rd(REG_STS, 16'h1800, 16'h1800, "page");
    rd(REG_STS, 16'h1000, 16'h0000, "page clr");
    pcsr_smi_ctrl_i.frame(OP_RD, 5'h02, REG_CTL, 16'h0000, rv);
    check("other phy", rv, 16'hFFFF);
    rd(5'h05, 16'hFFFF, 16'h0000, "unmapped");
    wr(5'h05, 16'hFFFF);
    rd(REG_CTL, 16'hFFFF, 16'h0008, "ctl kept");
    // Second reset with the strap low: bit 11 must follow it
    strap = 1'b0;
    rst_in = 1'b1;
    repeat (5) @(negedge mclk_in);
    rst_in = 1'b0;
    repeat (4) @(negedge mclk_in);
    rd(REG_CTL, 16'hFFFF, 16'h5048, "ctl rereset");
    bit1("sgmii", sge, 1'b0);
    report_and_stop();
  end
endmodule
`default_nettype wire

// ---- verilog/pcsr_mdio.sv ----
// Serial management frame engine, sampled on rising management clock
`timescale 1ns/1ps
`default_nettype none
module pcsr_mdio (
  input wire logic mclk_in,                          // core clock
  input wire logic rst_in,                           // sync reset
  input wire logic mdc_in,                           // management clock
  input wire logic mdio_in,                          // data pin level
  output logic mdio_out,                             // data pin drive
  output logic mdio_oe_out,                          // data pin enable
  input wire logic [pcsr_pkg::ADDR_W-1:0] phy_addr_in, // own address
  output logic [pcsr_pkg::ADDR_W-1:0] reg_addr_out,  // register addr
  output logic [pcsr_pkg::DATA_W-1:0] wr_data_out,   // write data
  output logic wr_stb_out,                           // write pulse
  output logic rd_stb_out,                           // read pulse
  input wire logic [pcsr_pkg::DATA_W-1:0] rd_data_in // read data
);
  import pcsr_pkg::*;
  typedef enum logic [1:0] {M_IDLE, M_HDR, M_TA, M_DATA} pcsr_mst_e;
  typedef struct packed {
    pcsr_mst_e st;
    logic [5:0] ones;
    logic [4:0] cnt;
    logic [15:0] sh;
    logic [15:0] tx;
    logic [4:0] ra;
    logic rd;
    logic mine;
    logic mdc_d;
    logic dout;
    logic oe;
    logic wstb;
    logic rstb;
  } pcsr_mdio_s;
  pcsr_mdio_s s_r, s_nxt;
  logic rise;
  logic [12:0] hdr;

  always_comb begin
    s_nxt = s_r;
    s_nxt.wstb = 1'b0;
    s_nxt.rstb = 1'b0;
    s_nxt.mdc_d = mdc_in;
    rise = mdc_in & ~s_r.mdc_d;
    hdr = {s_r.sh[11:0], mdio_in};
    if (rise) begin
      unique case (s_r.st)
        M_IDLE: begin
          if (mdio_in) begin
            if (s_r.ones != PRE_LEN) s_nxt.ones = s_r.ones + 6'h01;
          end else if (s_r.ones == PRE_LEN) begin
            s_nxt.st = M_HDR;
            s_nxt.cnt = 5'h00;
            s_nxt.ones = 6'h00;
          end else begin
            s_nxt.ones = 6'h00;
          end
        end
        M_HDR: begin
          s_nxt.sh = {s_r.sh[14:0], mdio_in};
          s_nxt.cnt = s_r.cnt + 5'h01;
          if (s_r.cnt == HDR_LEN - 5'h01) begin
            s_nxt.st = M_TA;
            s_nxt.cnt = 5'h00;
            s_nxt.ra = hdr[4:0];
            s_nxt.rd = (hdr[11:10] == OP_RD);
            // Foreign address or bad opcode: ride out the frame silently
            s_nxt.mine = hdr[12] && hdr[9:5] == phy_addr_in &&
                         (hdr[11:10] == OP_RD || hdr[11:10] == OP_WR);
            s_nxt.rstb = s_nxt.mine & s_nxt.rd;
          end
        end
        M_TA: begin
          s_nxt.cnt = s_r.cnt + 5'h01;
          if (s_r.cnt == 5'h00) begin
            s_nxt.oe = s_r.mine & s_r.rd;
            s_nxt.dout = 1'b0;
            s_nxt.tx = rd_data_in;
          end else begin
            s_nxt.st = M_DATA;
            s_nxt.cnt = 5'h00;
            s_nxt.dout = s_r.tx[15];
            s_nxt.tx = {s_r.tx[14:0], 1'b0};
          end
        end
        M_DATA: begin
          s_nxt.cnt = s_r.cnt + 5'h01;
          s_nxt.sh = {s_r.sh[14:0], mdio_in};
          s_nxt.dout = s_r.tx[15];
          s_nxt.tx = {s_r.tx[14:0], 1'b0};
          if (s_r.cnt == DAT_LEN - 5'h01) begin
            s_nxt.st = M_IDLE;
            s_nxt.oe = 1'b0;
            s_nxt.wstb = s_r.mine & ~s_r.rd;
          end
        end
      endcase
    end
  end

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      s_r <= '{st: M_IDLE, default: '0};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign mdio_out = s_r.dout;
  assign mdio_oe_out = s_r.oe;
  assign reg_addr_out = s_r.ra;
  assign wr_data_out = s_r.sh;
  assign wr_stb_out = s_r.wstb;
  assign rd_stb_out = s_r.rstb;
endmodule
`default_nettype wire

// ---- verilog/pcsr_pkg.sv ----
// Constants for the transceiver control and status register pair
// How it works
// R1: TX FIFO depth from control bits 15:14
// R2: RX FIFO depth 13:12, used only in SGMII
// R3: Bit 11 SGMII enable, reset from strap
// R4: Bit 10 forces link good
// R5: Power field 11: passive sleep, no wake
// R6: Power field 10: sleep, wake, 1.4s pulses
// R7: Power field 01: sleep, PLL off if clock on
// R8: Bit 7 turns power-down into deep power-down
// R9: Bits 6:5 crossover select, reset 10
// R10: Bit 4 disables 125 MHz clock output
// R11: Bit 3 reserved, reads 1, writes ignored
// R12: Bit 2 standby: powered, no link
// R13: Bit 1 inverts line driver output
// R14: Bit 0 disables jabber, reset 0
// R15: Status 15:13 speed and duplex
// R16: Status 12 page latch, clear on read
// R17: Status 11 negotiation resolved or disabled
// R18: Status 10 link up
// R19: Status 9:8 pair swap per pair group
// R20: Status 7 downshift during negotiation
// R21: Status 6 sleep state
// R22: Status 5:2 channel polarity on gigabit link
// R23: Status writes ignored, fields follow live state
package pcsr_pkg;
  localparam int ADDR_W = 5;
  localparam int DATA_W = 16;
  localparam logic [4:0] REG_CTL = 5'h10;
  localparam logic [4:0] REG_STS = 5'h11;
  // Control field positions
  localparam int C_TXD = 14;
  localparam int C_RXD = 12;
  localparam int C_SGM = 11;
  localparam int C_FLG = 10;
  localparam int C_PWR = 8;
  localparam int C_DPD = 7;
  localparam int C_XOV = 5;
  localparam int C_CKD = 4;
  localparam int C_RSV = 3;
  localparam int C_STB = 2;
  localparam int C_INV = 1;
  localparam int C_JAB = 0;
  localparam logic [15:0] CTL_RST = 16'h5048;
  localparam logic [15:0] CTL_WMASK = 16'hFFF7;
  localparam logic [15:0] CTL_ONES = 16'h0008;
  // Status field positions
  localparam int S_SPD = 14;
  localparam int S_DUP = 13;
  localparam int S_PAGE = 12;
  localparam int S_RES = 11;
  localparam int S_LNK = 10;
  localparam int S_XCD = 9;
  localparam int S_XAB = 8;
  localparam int S_DSH = 7;
  localparam int S_SLP = 6;
  localparam int S_POL = 2;
  // Encodings
  localparam logic [1:0] SPD_1000 = 2'h2;
  localparam logic [1:0] PWR_NORM = 2'h0;
  localparam logic [1:0] PWR_IEEE = 2'h1;
  localparam logic [1:0] PWR_ACT = 2'h2;
  localparam logic [1:0] PWR_PAS = 2'h3;
  localparam logic [1:0] XOV_MDIX = 2'h1;
  localparam logic [1:0] OP_WR = 2'h1;
  localparam logic [1:0] OP_RD = 2'h2;
  localparam logic [5:0] PRE_LEN = 6'h20;
  localparam logic [4:0] HDR_LEN = 5'h0D;
  localparam logic [4:0] DAT_LEN = 5'h10;
  // Timing
  localparam int CLK_KHZ = 125000;
  localparam int PULSE_MS = 1400;
  localparam int PULSE_CYC_DEF = PULSE_MS * CLK_KHZ;
  // FIFO depth code to entries
  function automatic logic [3:0] pcsr_depth(input logic [1:0] code);
    unique case (code)
      2'h3: pcsr_depth = 4'h8;
      2'h2: pcsr_depth = 4'h6;
      2'h1: pcsr_depth = 4'h4;
      default: pcsr_depth = 4'h3;
    endcase
  endfunction
endpackage

// ---- verilog/pcsr_regs.sv ----
// Control and status register pair with the control it exerts
`timescale 1ns/1ps
`default_nettype none
module pcsr_regs #(
  parameter int unsigned PULSE_CYC = pcsr_pkg::PULSE_CYC_DEF // wake pulse
) (
  input wire logic mclk_in,              // 125 MHz clock
  input wire logic rst_in,               // sync reset
  input wire logic mdc_in,               // management clock
  input wire logic mdio_in,              // management data in
  output logic mdio_out,                 // management data out
  output logic mdio_oe_out,              // management data enable
  input wire logic [pcsr_pkg::ADDR_W-1:0] phy_addr_in, // own address
  input wire logic sgmii_strap_in,       // strap for SGMII enable
  input wire logic [1:0] speed_in,       // resolved speed
  input wire logic full_duplex_in,       // resolved duplex
  input wire logic page_rx_in,           // page received pulse
  input wire logic an_enabled_in,        // negotiation enabled
  input wire logic an_done_in,           // negotiation complete
  input wire logic an_busy_in,           // negotiation running
  input wire logic link_qual_in,         // qualified link
  input wire logic pair_cd_swapped_in,   // C/D pairs crossed
  input wire logic pair_ab_swapped_in,   // A/B pairs crossed
  input wire logic downshift_active_in,  // gigabit masked
  input wire logic [3:0] channel_polarity_flip_in, // D,C,B,A reversed
  input wire logic partner_detect_in,    // energy from partner
  input wire logic pd_pin_in,            // power-down pin
  input wire logic basic_control_pd_in,  // basic control power-down
  output logic [3:0] tx_fifo_depth_out,  // TX FIFO entries
  output logic tx_fifo_en_out,           // TX FIFO in use
  output logic [3:0] rx_fifo_depth_out,  // RX FIFO entries
  output logic rx_fifo_en_out,           // RX FIFO in use
  output logic sgmii_en_out,             // serial MAC enabled
  output logic link_up_out,              // link state
  output logic sleep_out,                // asleep
  output logic block_pd_out,             // digital/analog down
  output logic pll_pd_out,               // PLL down
  output logic link_pulse_out,           // wake pulse request
  output logic pd_out,                   // ordinary power-down
  output logic deep_pd_out,              // deep power-down
  output logic pair_swap_auto_out,       // auto crossover
  output logic pair_swap_select_out,     // forced crossed pairing
  output logic fast_clock_out_en_out,    // 125 MHz output on
  output logic tx_invert_on_out,         // invert line drivers
  output logic jabber_en_out             // jabber function on
);
  import pcsr_pkg::*;
  typedef enum logic {PW_RUN, PW_SLEEP} pcsr_pw_e;
  typedef struct packed {
    logic [15:0] ctl;
    logic [15:0] rdat;
    logic [31:0] pcnt;
    pcsr_pw_e pw;
    logic page;
    logic strap_done;
    logic pulse;
  } pcsr_regs_s;
  pcsr_regs_s s_r, s_nxt;
  logic [4:0] ra;
  logic [15:0] wd, sts;
  logic wstb, rstb;
  logic [1:0] pmode;
  logic gig_link, pd_req;

  pcsr_mdio u_mdio (
    .mclk_in(mclk_in),
    .rst_in(rst_in),
    .mdc_in(mdc_in),
    .mdio_in(mdio_in),
    .mdio_out(mdio_out),
    .mdio_oe_out(mdio_oe_out),
    .phy_addr_in(phy_addr_in),
    .reg_addr_out(ra),
    .wr_data_out(wd),
    .wr_stb_out(wstb),
    .rd_stb_out(rstb),
    .rd_data_in(s_r.rdat)
  );

  assign pmode = s_r.ctl[C_PWR +: 2];
  assign link_up_out = ~s_r.ctl[C_STB] & (s_r.pw == PW_RUN) &
                       (s_r.ctl[C_FLG] | link_qual_in); // R4 R12
  assign gig_link = link_up_out & (speed_in == SPD_1000);

  // Live status image; only the page latch holds history
  always_comb begin
    sts = '0;
    sts[S_SPD +: 2] = speed_in; // R15
    sts[S_DUP] = full_duplex_in; // R15
    sts[S_PAGE] = s_r.page; // R16
    sts[S_RES] = an_done_in | ~an_enabled_in; // R17
    sts[S_LNK] = link_up_out; // R18
    sts[S_XCD] = pair_cd_swapped_in; // R19
    sts[S_XAB] = pair_ab_swapped_in; // R19
    sts[S_DSH] = downshift_active_in & an_busy_in; // R20
    sts[S_SLP] = (s_r.pw == PW_SLEEP); // R21
    sts[S_POL +: 4] = channel_polarity_flip_in & {4{gig_link}}; // R22
  end

  always_comb begin
    s_nxt = s_r;
    s_nxt.pulse = 1'b0;
    s_nxt.strap_done = 1'b1;
    // Strap caught on the first edge after reset release
    if (!s_r.strap_done) s_nxt.ctl[C_SGM] = sgmii_strap_in; // R3
    if (wstb && ra == REG_CTL) begin
      s_nxt.ctl = (wd & CTL_WMASK) | CTL_ONES; // R3 R11
    end
    // Writes to the status address fall through untouched R23
    if (rstb) begin
      s_nxt.rdat = (ra == REG_CTL) ? s_r.ctl :
                   (ra == REG_STS) ? sts : 16'h0000;
      if (ra == REG_STS) s_nxt.page = 1'b0; // R16
    end
    // New page wins over a clearing read in the same cycle
    if (page_rx_in) s_nxt.page = 1'b1; // R16
    unique case (s_r.pw)
      PW_RUN: begin
        // Active sleep holds off while a partner or link is present
        if (pmode == PWR_PAS || pmode == PWR_IEEE ||
            (pmode == PWR_ACT && !partner_detect_in && !link_qual_in)) begin
          s_nxt.pw = PW_SLEEP; // R5 R6 R7
          s_nxt.pcnt = '0;
        end
      end
      PW_SLEEP: begin
        s_nxt.pcnt = s_r.pcnt + 32'h1;
        if (s_r.pcnt == 32'(PULSE_CYC - 1)) begin
          s_nxt.pcnt = '0;
          s_nxt.pulse = (pmode == PWR_ACT); // R6
        end
        if (pmode == PWR_NORM || (pmode == PWR_ACT && partner_detect_in)) begin
          s_nxt.pw = PW_RUN; // R6
        end
      end
    endcase
  end

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      s_r <= '{ctl: CTL_RST, pw: PW_RUN, default: '0};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign tx_fifo_depth_out = pcsr_depth(s_r.ctl[C_TXD +: 2]); // R1
  assign rx_fifo_depth_out = pcsr_depth(s_r.ctl[C_RXD +: 2]); // R2
  assign sgmii_en_out = s_r.ctl[C_SGM]; // R3
  // GMII path buffers TX only at gigabit and RX never; SGMII buffers both at every speed
  assign tx_fifo_en_out = s_r.ctl[C_SGM] | (speed_in == SPD_1000); // R1
  assign rx_fifo_en_out = s_r.ctl[C_SGM]; // R2
  assign sleep_out = (s_r.pw == PW_SLEEP); // R21
  assign block_pd_out = sleep_out; // R5 R6 R7
  assign pll_pd_out = sleep_out & (pmode == PWR_IEEE) &
                      ~s_r.ctl[C_CKD]; // R7 R10
  assign link_pulse_out = s_r.pulse; // R6
  assign pd_req = pd_pin_in | basic_control_pd_in;
  assign deep_pd_out = pd_req & s_r.ctl[C_DPD]; // R8
  assign pd_out = pd_req & ~s_r.ctl[C_DPD]; // R8
  assign pair_swap_auto_out = s_r.ctl[C_XOV + 1]; // R9
  assign pair_swap_select_out = s_r.ctl[C_XOV +: 2] == XOV_MDIX; // R9
  assign fast_clock_out_en_out = ~s_r.ctl[C_CKD]; // R10
  assign tx_invert_on_out = s_r.ctl[C_INV]; // R13
  assign jabber_en_out = ~s_r.ctl[C_JAB]; // R14

  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (rst_in);

  sequence ctl_write_s;
    wstb && ra == REG_CTL;
  endsequence
  sequence sts_read_s;
    rstb && ra == REG_STS && !page_rx_in;
  endsequence

  tx_depth_a: assert property (ctl_write_s |=> // R1
    tx_fifo_depth_out == pcsr_depth($past(wd[15:14])) &&
    rx_fifo_depth_out == pcsr_depth($past(wd[13:12])))
    else $error("fifo depth not taken from write");
  rx_fifo_a: assert property (rx_fifo_en_out == sgmii_en_out) // R2
    else $error("rx fifo enable differs from sgmii");
  strap_a: assert property (!s_r.strap_done && !wstb |=> // R3
    sgmii_en_out == $past(sgmii_strap_in))
    else $error("strap not loaded");
  force_a: assert property (s_r.ctl[C_FLG] && !s_r.ctl[C_STB] && // R4
    !sleep_out |-> link_up_out)
    else $error("forced link not up");
  passive_a: assert property (sleep_out && pmode == PWR_PAS // R5
    && !(wstb && ra == REG_CTL) |=> sleep_out)
    else $error("passive sleep woke");
  wake_a: assert property (sleep_out && pmode == PWR_ACT && // R6
    partner_detect_in |=> !sleep_out)
    else $error("active sleep did not wake");
  pll_a: assert property (pll_pd_out |-> sleep_out && // R7
    pmode == PWR_IEEE && fast_clock_out_en_out)
    else $error("pll down in wrong mode");
  deep_a: assert property (pd_req |-> deep_pd_out != pd_out) // R8
    else $error("power-down kind wrong");
  rsv_a: assert property (ctl_write_s |=> s_r.ctl[C_RSV] && // R11
    s_r.ctl[15:4] == $past(wd[15:4]) && s_r.ctl[2:0] == $past(wd[2:0]))
    else $error("control write wrong");
  standby_a: assert property (s_r.ctl[C_STB] |-> !link_up_out) // R12
    else $error("link up in standby");
  page_set_a: assert property (page_rx_in |=> sts[S_PAGE]) // R16
    else $error("page latch lost");
  page_clr_a: assert property (sts_read_s ##1 !page_rx_in |=> // R16
    !sts[S_PAGE])
    else $error("page latch not cleared");
  spd_read_a: assert property (rstb && ra == REG_STS |=> // R15
    s_r.rdat[15:13] == $past({speed_in, full_duplex_in}))
    else $error("status read speed wrong");
  swap_read_a: assert property (rstb && ra == REG_STS |=> // R19
    s_r.rdat[9:8] == $past({pair_cd_swapped_in, pair_ab_swapped_in}))
    else $error("status read pair swap wrong");
endmodule
`default_nettype wire
